/* File: include/power_tap_regs.vh */
/*
 Register offsets, field positions, reset values, codes and time units
 for the power mode and tap configuration bank.
 Assumes inclusion by bare name from files that need these definitions.
*/
`ifndef POWER_TAP_REGS_VH
`define POWER_TAP_REGS_VH

// Register offsets
`define POWER_MODE_CONTROL_ADDR 8'h2d
`define BUILT_IN_CHECK_CONTROL_ADDR 8'h2e
`define TAP_LEVEL_LIMIT_ADDR 8'h2f
`define TAP_MAX_LENGTH_ADDR 8'h30
`define DOUBLE_TAP_WAIT_ADDR 8'h31
`define SECOND_TAP_INTERVAL_ADDR 8'h32

// Reset values
`define POWER_MODE_CONTROL_RST 8'h00
`define BUILT_IN_CHECK_CONTROL_RST 8'h00
`define TAP_LEVEL_LIMIT_RST 8'h00
`define TAP_MAX_LENGTH_RST 8'h00
`define DOUBLE_TAP_WAIT_RST 8'h00
`define SECOND_TAP_INTERVAL_RST 8'h00

// Writable bits; reserved bits store and read as zero
`define POWER_MODE_CONTROL_MASK 8'h7f
`define BUILT_IN_CHECK_CONTROL_MASK 8'h03

// Field positions in power_mode_control
`define OUTSIDE_TIMEBASE_BIT 6
`define NOISE_MODE_MSB 5
`define NOISE_MODE_LSB 4
`define LOW_RATE_WAKE_BIT 3
`define AUTO_DOZE_BIT 2
`define RUN_MODE_MSB 1
`define RUN_MODE_LSB 0

// Field positions in built_in_check_control
`define FORCED_CHECK_BIT 1
`define CHECK_ENABLE_BIT 0

// Codes
`define RUN_MODE_STANDBY 2'h0
`define RUN_MODE_RUN_MODE_SELECT 2'h2
`define NOISE_MODE_NORMAL 2'h0
`define NOISE_MODE_LOW 2'h1
`define NOISE_MODE_ULTRALOW 2'h2
`define MOTION_LINK_BIT 0

// Time units, in nanoseconds
`define TAP_LENGTH_UNIT_NS 625000
`define TAP_WAIT_UNIT_NS 1250000
`define ODR_BASE_PERIOD_NS 80000000
`define ODR_MAX_CODE 3'h5

`endif

/* File: hdl/tap_event_detector.v */
/*
 Single and double tap detector working once per acceleration sample.
 Assumes sample_valid is a one-cycle pulse on ref_clk and that all time
 settings arrive already converted to sample periods.
*/
`default_nettype none

module tap_event_detector
(
    // Clock, reset, enable
    input wire ref_clk,
    input wire nrst,
    input wire ce,
    // Sample stream
    input wire sample_valid,
    input wire [7:0] tap_magnitude,
    // Settings
    input wire detect_enable,
    input wire double_enable,
    input wire [7:0] tap_level,
    input wire [7:0] length_samples,
    input wire [7:0] wait_samples,
    input wire [7:0] span_samples,
    // Events
    output reg single_tap,
    output reg double_tap
);

    localparam [2:0] ST_IDLE = 3'h0;
    localparam [2:0] ST_ABOVE = 3'h1;
    localparam [2:0] ST_WAIT = 3'h2;
    localparam [2:0] ST_SPAN = 3'h3;
    localparam [2:0] ST_SECOND = 3'h4;
    localparam [2:0] ST_SETTLE = 3'h5;

    reg [2:0] state_q;
    reg [2:0] state_d;
    reg [7:0] len_q;
    reg [7:0] len_d;
    reg [7:0] time_q;
    reg [7:0] time_d;
    reg single_d;
    reg double_d;
    wire above;
    wire [8:0] time_next;

    assign above = tap_magnitude > tap_level; // R6
    assign time_next = {1'b0, time_q} + 9'h001;

    always @*
    begin
        state_d = state_q;
        len_d = len_q;
        time_d = time_q;
        single_d = 1'b0;
        double_d = 1'b0;
        if (!detect_enable)
        begin
            state_d = ST_IDLE; // R7
        end
        else if (sample_valid) // R12
        begin
            case (state_q)
                ST_IDLE:
                begin
                    if (above)
                    begin
                        len_d = 8'h01;
                        state_d = (length_samples == 8'h00) ? ST_SETTLE : ST_ABOVE;
                    end
                end
                ST_ABOVE, ST_SECOND:
                begin
                    if (above)
                    begin
                        if (len_q >= length_samples)
                        begin
                            state_d = ST_SETTLE; // R8
                        end
                        else
                        begin
                            len_d = len_q + 8'h01;
                        end
                    end
                    else if (state_q == ST_SECOND)
                    begin
                        double_d = double_enable; // R10 R11
                        state_d = ST_IDLE;
                    end
                    else
                    begin
                        single_d = 1'b1;
                        time_d = 8'h00;
                        state_d = double_enable ? ST_WAIT : ST_IDLE; // R10
                    end
                end
                ST_WAIT:
                begin
                    if (time_next >= {1'b0, wait_samples})
                    begin
                        time_d = 8'h00;
                        state_d = ST_SPAN; // R9
                    end
                    else
                    begin
                        time_d = time_next[7:0];
                    end
                end
                ST_SPAN:
                begin
                    if (above)
                    begin
                        len_d = 8'h01;
                        state_d = (length_samples == 8'h00) ? ST_SETTLE : ST_SECOND;
                    end
                    else if (time_next >= {1'b0, span_samples})
                    begin
                        state_d = ST_IDLE; // R11
                    end
                    else
                    begin
                        time_d = time_next[7:0];
                    end
                end
                ST_SETTLE:
                begin
                    if (!above)
                    begin
                        state_d = ST_IDLE;
                    end
                end
                default:
                begin
                    state_d = ST_IDLE;
                end
            endcase
        end
    end

    always @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            state_q <= ST_IDLE;
            len_q <= 8'h00;
            time_q <= 8'h00;
            single_tap <= 1'b0;
            double_tap <= 1'b0;
        end
        else if (ce)
        begin
            state_q <= state_d;
            len_q <= len_d;
            time_q <= time_d;
            single_tap <= single_d;
            double_tap <= double_d;
        end
    end

endmodule

`default_nettype wire

/* File: hdl/power_tap_config.v */
/*
 Power mode and tap configuration register bank with sample timebase
 selection, time-setting conversion and the tap detector.
 Assumes the serial port decoder presents single-cycle register accesses
 on ref_clk, and the sensing logic gives tap magnitudes in threshold units.
*/
`default_nettype none

`include "power_tap_regs.vh"

// Contract
// R1: run mode 00 standby, 10 run_mode_select
// R2: noise field selects power/noise mode
// R3: auto doze only under linked/loop
// R4: external timebase bit selects outside clock
// R5: wake bit selects wake-up mode
// R6: tap magnitude compared to eight-bit level
// R7: zero level disables all tap detection
// R8: tap longer than length is rejected
// R9: wait time before second-tap span
// R10: zero wait disables double tap
// R11: double tap needs second tap inside span
// R12: times converted to whole sample periods
// R13: host writes no reserved codes
module power_tap_config
(
    // Clock, reset, enable
    input wire ref_clk,
    input wire nrst,
    input wire ce,
    // Register access from the serial port
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata,
    // Context from other registers and timebases
    input wire [1:0] motion_link_mode,
    input wire [2:0] odr_sel,
    input wire int_sample_tick,
    input wire outside_timebase_pin,
    // Sample stream
    input wire sample_valid,
    input wire [7:0] tap_magnitude,
    // Mode outputs
    output reg run_mode_select_active,
    output reg [1:0] noise_mode,
    output reg low_rate_motion_wake,
    output reg auto_doze_active,
    output reg outside_timebase_select,
    output reg check_enable,
    output reg forced_check,
    output reg sample_start,
    // Tap events
    output wire single_tap,
    output wire double_tap
);

    localparam integer LEN_SHIFT_BASE = $clog2(`ODR_BASE_PERIOD_NS / `TAP_LENGTH_UNIT_NS);
    localparam integer WAIT_SHIFT_BASE = $clog2(`ODR_BASE_PERIOD_NS / `TAP_WAIT_UNIT_NS);

    reg [7:0] power_mode_control_q;
    reg [7:0] built_in_check_control_q;
    reg [7:0] tap_level_limit_q;
    reg [7:0] tap_max_length_q;
    reg [7:0] double_tap_wait_q;
    reg [7:0] second_tap_interval_q;
    reg [7:0] rdata_d;

    reg ext_sync1_q;
    reg ext_sync2_q;
    reg ext_prev_q;
    wire ext_edge;
    wire tick_sel;

    reg [2:0] odr_code;
    reg [3:0] len_shift;
    reg [3:0] wait_shift;
    wire [7:0] length_samples;
    wire [7:0] wait_samples;
    wire [7:0] span_samples;
    wire detect_enable;
    wire double_enable;

    // Register writes
    always @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            power_mode_control_q <= `POWER_MODE_CONTROL_RST;
            built_in_check_control_q <= `BUILT_IN_CHECK_CONTROL_RST;
            tap_level_limit_q <= `TAP_LEVEL_LIMIT_RST;
            tap_max_length_q <= `TAP_MAX_LENGTH_RST;
            double_tap_wait_q <= `DOUBLE_TAP_WAIT_RST;
            second_tap_interval_q <= `SECOND_TAP_INTERVAL_RST;
        end
        else if (ce && reg_wr)
        begin
            case (reg_addr)
                `POWER_MODE_CONTROL_ADDR:
                begin
                    power_mode_control_q <= reg_wdata & `POWER_MODE_CONTROL_MASK;
                end
                `BUILT_IN_CHECK_CONTROL_ADDR:
                begin
                    built_in_check_control_q <= reg_wdata & `BUILT_IN_CHECK_CONTROL_MASK;
                end
                `TAP_LEVEL_LIMIT_ADDR:
                begin
                    tap_level_limit_q <= reg_wdata; // R6
                end
                `TAP_MAX_LENGTH_ADDR:
                begin
                    tap_max_length_q <= reg_wdata;
                end
                `DOUBLE_TAP_WAIT_ADDR:
                begin
                    double_tap_wait_q <= reg_wdata;
                end
                `SECOND_TAP_INTERVAL_ADDR:
                begin
                    second_tap_interval_q <= reg_wdata;
                end
                default:
                begin
                    power_mode_control_q <= power_mode_control_q;
                end
            endcase
        end
    end

    // Read mux; unmapped offsets read zero
    always @*
    begin
        case (reg_addr)
            `POWER_MODE_CONTROL_ADDR: rdata_d = power_mode_control_q;
            `BUILT_IN_CHECK_CONTROL_ADDR: rdata_d = built_in_check_control_q;
            `TAP_LEVEL_LIMIT_ADDR: rdata_d = tap_level_limit_q;
            `TAP_MAX_LENGTH_ADDR: rdata_d = tap_max_length_q;
            `DOUBLE_TAP_WAIT_ADDR: rdata_d = double_tap_wait_q;
            `SECOND_TAP_INTERVAL_ADDR: rdata_d = second_tap_interval_q;
            default: rdata_d = 8'h00;
        endcase
    end

    always @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            reg_rdata <= 8'h00;
        end
        else if (ce && reg_rd)
        begin
            reg_rdata <= rdata_d;
        end
    end

    // Mode decode, registered so outputs come from flip-flops
    always @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            run_mode_select_active <= 1'b0;
            noise_mode <= `NOISE_MODE_NORMAL;
            low_rate_motion_wake <= 1'b0;
            auto_doze_active <= 1'b0;
            outside_timebase_select <= 1'b0;
            check_enable <= 1'b0;
            forced_check <= 1'b0;
        end
        else if (ce)
        begin
            // Reserved run codes behave as standby
            run_mode_select_active <= power_mode_control_q[`RUN_MODE_MSB:`RUN_MODE_LSB] == `RUN_MODE_RUN_MODE_SELECT; // R1
            noise_mode <= power_mode_control_q[`NOISE_MODE_MSB:`NOISE_MODE_LSB]; // R2
            low_rate_motion_wake <= power_mode_control_q[`LOW_RATE_WAKE_BIT]; // R5
            auto_doze_active <= power_mode_control_q[`AUTO_DOZE_BIT]
                                & motion_link_mode[`MOTION_LINK_BIT]; // R3
            outside_timebase_select <= power_mode_control_q[`OUTSIDE_TIMEBASE_BIT]; // R4
            check_enable <= built_in_check_control_q[`CHECK_ENABLE_BIT];
            forced_check <= built_in_check_control_q[`FORCED_CHECK_BIT];
        end
    end

    // Outside timebase pin: two-stage synchroniser, then edge detect
    always @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            ext_sync1_q <= 1'b0;
            ext_sync2_q <= 1'b0;
            ext_prev_q <= 1'b0;
        end
        else if (ce)
        begin
            ext_sync1_q <= outside_timebase_pin;
            ext_sync2_q <= ext_sync1_q;
            ext_prev_q <= ext_sync2_q;
        end
    end

    assign ext_edge = ext_sync2_q & ~ext_prev_q;
    assign tick_sel = outside_timebase_select ? ext_edge : int_sample_tick; // R4

    // Conversion starts only while measuring
    always @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            sample_start <= 1'b0;
        end
        else if (ce)
        begin
            sample_start <= tick_sel & run_mode_select_active;
        end
    end

    // Time settings to sample periods; reserved rate codes clamp to the fastest
    always @*
    begin
        odr_code = (odr_sel > `ODR_MAX_CODE) ? `ODR_MAX_CODE : odr_sel;
        len_shift = LEN_SHIFT_BASE[3:0] - {1'b0, odr_code};
        wait_shift = WAIT_SHIFT_BASE[3:0] - {1'b0, odr_code};
    end

    to_samples #(.W(8)) conv_len (.count(tap_max_length_q), .shift(len_shift), .samples(length_samples)); // R12
    to_samples #(.W(8)) conv_wait (.count(double_tap_wait_q), .shift(wait_shift), .samples(wait_samples)); // R12
    to_samples #(.W(8)) conv_span (.count(second_tap_interval_q), .shift(wait_shift), .samples(span_samples)); // R12

    assign detect_enable = run_mode_select_active & (tap_level_limit_q != 8'h00); // R7
    assign double_enable = double_tap_wait_q != 8'h00; // R10

    tap_event_detector detector
    (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .ce(ce),
        .sample_valid(sample_valid),
        .tap_magnitude(tap_magnitude),
        .detect_enable(detect_enable),
        .double_enable(double_enable),
        .tap_level(tap_level_limit_q),
        .length_samples(length_samples),
        .wait_samples(wait_samples),
        .span_samples(span_samples),
        .single_tap(single_tap),
        .double_tap(double_tap)
    );

endmodule

// Shift a unit count into sample periods; a nonzero count gives at least one
module to_samples
#(
    parameter W = 8
)
(
    input wire [W-1:0] count,
    input wire [3:0] shift,
    output wire [W-1:0] samples
);

    wire [W-1:0] shifted;

    assign shifted = count >> shift;
    assign samples = ((count != {W{1'b0}}) && (shifted == {W{1'b0}})) ? {{(W-1){1'b0}}, 1'b1} : shifted;

endmodule

`default_nettype wire

/* File: tb/power_tap_config_properties.sv */
/*
 Port checker for the power mode and tap register bank.
 Assumes it is bound into power_tap_config; ce may drop between requests.
*/
`default_nettype none
module power_tap_config_properties (
    // Clock, reset, register port
    input wire logic ref_clk, nrst, ce, reg_wr, reg_rd,
    input wire logic [7:0] reg_addr, reg_wdata, reg_rdata,
    // Context and samples
    input wire logic [1:0] motion_link_mode,
    input wire logic [2:0] odr_sel,
    input wire logic int_sample_tick, outside_timebase_pin, sample_valid,
    input wire logic [7:0] tap_magnitude,
    // Mode outputs and events
    input wire logic run_mode_select_active, low_rate_motion_wake, auto_doze_active,
    input wire logic [1:0] noise_mode,
    input wire logic outside_timebase_select, check_enable, forced_check,
    input wire logic sample_start, single_tap, double_tap
);
    logic pwr_wr;
    logic wait_zero_q;
    logic [7:0] lvl_q;
    assign pwr_wr = ce && reg_wr && reg_addr == 8'h2d;
    // Shadow of the settings that gate tap detection
    always @(posedge ref_clk or negedge nrst)
        if (!nrst)
        begin
            lvl_q <= 8'h00;
            wait_zero_q <= 1'b1;
        end
        else if (ce && reg_wr && reg_addr == 8'h2f)
            lvl_q <= reg_wdata;
        else if (ce && reg_wr && reg_addr == 8'h31)
            wait_zero_q <= reg_wdata == 8'h00;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    sequence s_pwr_write;
        pwr_wr ##1 !pwr_wr;
    endsequence
    chk_run_mode: assert property (s_pwr_write |=>
        run_mode_select_active == ($past(reg_wdata[1:0], 2) == 2'b10)) else $error("run mode output wrong");
    chk_noise_mode: assert property (s_pwr_write |=>
        noise_mode == $past(reg_wdata[5:4], 2)) else $error("noise mode output wrong");
    chk_auto_doze: assert property (s_pwr_write |=>
        auto_doze_active == ($past(reg_wdata[2], 2) && $past(motion_link_mode[0]))) else $error("doze wrong");
    chk_ext_clock: assert property (s_pwr_write |=>
        outside_timebase_select == $past(reg_wdata[6], 2)) else $error("timebase select wrong");
    chk_wake_bit: assert property (s_pwr_write |=>
        low_rate_motion_wake == $past(reg_wdata[3], 2)) else $error("wake output wrong");
    chk_tick_start: assert property (ce && int_sample_tick && run_mode_select_active &&
        !outside_timebase_select |=> sample_start) else $error("tick gave no sample start");
    chk_standby_quiet: assert property (!run_mode_select_active [*3] |->
        !sample_start && !single_tap && !double_tap) else $error("activity in standby");
    chk_level_off: assert property ((lvl_q == 8'h00) [*3] |->
        !single_tap && !double_tap) else $error("tap with zero level");
    chk_double_off: assert property (wait_zero_q [*3] |-> !double_tap)
        else $error("double tap with zero wait");
    chk_tap_cause: assert property (single_tap || double_tap |->
        $past(sample_valid) && $past(tap_magnitude) <= lvl_q) else $error("tap without ending sample");
    chk_unmapped_read: assert property (ce && reg_rd && (reg_addr < 8'h2d || reg_addr > 8'h32)
        |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
    chk_rdata_hold: assert property (!(ce && reg_rd) |=> $stable(reg_rdata))
        else $error("read data moved");
endmodule
`default_nettype wire

/* File: tb/host_port_model.sv */
/*
 Host side of the register port: single byte writes and reads.
 Assumes strobes are taken at the rising ref_clk edge.
*/
`default_nettype none
module host_port_model (
    // Clock and answer
    input wire logic ref_clk,
    input wire logic [7:0] reg_rdata,
    // Request
    output logic [7:0] reg_addr, reg_wdata,
    output logic reg_wr, reg_rd
);
    timeunit 1ns;
    timeprecision 100ps;
    initial
    begin
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end
    // Callers keep reserved bits and codes at zero
    task automatic wr(input logic [7:0] a, d);
        @(posedge ref_clk);
        #1;
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(posedge ref_clk);
        #1;
        reg_wr = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        #1;
        reg_addr = a;
        reg_rd = 1'b1;
        @(posedge ref_clk);
        #1;
        reg_rd = 1'b0;
        reg_addr = ~a;
        d = reg_rdata;
    endtask
endmodule
`default_nettype wire

/* File: tb/test_power_tap_config.sv */
/*
 Self-checking bench for the power mode and tap register bank.
 Assumes odr code 5 (code 3 in one tap case), so length = count >> 2 and wait/span = count >> 1.
*/
`default_nettype none
module test_power_tap_config;
    timeunit 1ns;
    timeprecision 100ps;
    logic ref_clk, nrst, ce, reg_wr, reg_rd, int_sample_tick, outside_timebase_pin, sample_valid;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, tap_magnitude;
    logic [1:0] motion_link_mode, noise_mode;
    logic [2:0] odr_sel;
    logic run_mode_select_active, low_rate_motion_wake, auto_doze_active, outside_timebase_select;
    logic check_enable, forced_check, sample_start, single_tap, double_tap;
    int failures = 0;
    int num_checks = 0;
    power_tap_config dut (.*);
    host_port_model host (.*);
    initial
    begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    task automatic check(input string what, input logic [7:0] seen, exp);
        num_checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wrap_up;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic t_reset;
        logic [7:0] d;
        for (int a = 8'h2c; a <= 8'h33; a++)
        begin
            host.rd(a[7:0], d);
            check("reset read", d, 8'h00);
        end
        check("reset outputs", {run_mode_select_active, noise_mode, auto_doze_active, check_enable, sample_start,
            single_tap, double_tap}, 8'h00);
        $display("test reset done");
    endtask
    task automatic t_modes;
        logic [7:0] vals[6] = '{8'h02, 8'h12, 8'h20, 8'h48, 8'h06, 8'h06};
        logic [7:0] d;
        for (int i = 0; i < 6; i++)
        begin
            motion_link_mode = (i == 5) ? 2'b11 : (i == 3) ? 2'b01 : 2'b10;
            host.wr(8'h2d, vals[i]);
            host.rd(8'h2d, d);
            check("power readback", d, vals[i]);
            check("mode outputs", {run_mode_select_active, noise_mode, low_rate_motion_wake, auto_doze_active,
                outside_timebase_select}, {vals[i][1:0] == 2'b10, vals[i][5:3], vals[i][2] & (i == 5),
                vals[i][6]});
        end
        host.wr(8'h2e, 8'h02);
        host.rd(8'h2e, d);
        check("self check", {d[1:0], check_enable, forced_check}, 4'b1001);
        for (int a = 8'h2f; a <= 8'h32; a++)
        begin
            host.wr(a[7:0], 8'h80 | a[7:0]);
            host.rd(a[7:0], d);
            check("tap setting", d, 8'h80 | a[7:0]);
        end
        $display("test modes done");
    endtask
    task automatic tick_try(input logic pin, input logic [7:0] exp);
        logic [7:0] n;
        n = 8'h00;
        @(posedge ref_clk);
        #1;
        int_sample_tick = !pin;
        outside_timebase_pin = pin;
        for (int k = 0; k < 8; k++)
        begin
            @(posedge ref_clk);
            #1;
            int_sample_tick = 1'b0;
            n = n + sample_start;
        end
        outside_timebase_pin = 1'b0;
        check("sample starts", n, exp);
    endtask
    task automatic t_tick;
        host.wr(8'h2d, 8'h02);
        tick_try(1'b0, 8'h01);
        tick_try(1'b1, 8'h00);
        host.wr(8'h2d, 8'h42);
        tick_try(1'b1, 8'h01);
        tick_try(1'b0, 8'h00);
        host.wr(8'h2d, 8'h40);
        tick_try(1'b1, 8'h00);
        $display("test tick done");
    endtask
    task automatic samp(input logic [7:0] m, input logic [1:0] exp);
        logic [1:0] seen;
        seen = 2'b00;
        @(posedge ref_clk);
        #1;
        sample_valid = 1'b1;
        tap_magnitude = m;
        for (int k = 0; k < 4; k++)
        begin
            @(posedge ref_clk);
            #1;
            sample_valid = 1'b0;
            tap_magnitude = ~m;
            seen = seen | {single_tap, double_tap};
        end
        check("tap events", seen, exp);
    endtask
    task automatic seq(input logic [7:0] ms[$], input logic [1:0] es[$]);
        foreach (ms[i])
            samp(ms[i], es[i]);
    endtask
    task automatic cfg(input logic [7:0] lvl, dur, lat, win);
        host.wr(8'h2f, 8'h00);
        host.wr(8'h30, dur);
        host.wr(8'h31, lat);
        host.wr(8'h32, win);
        host.wr(8'h2f, lvl);
    endtask
    task automatic t_taps;
        logic [7:0] d;
        host.wr(8'h2d, 8'h02);
        cfg(8'h10, 8'h08, 8'h02, 8'h04);
        seq('{8'h10, 8'h01}, '{2'b00, 2'b00});
        seq('{8'h11, 8'h01, 8'h01, 8'h11, 8'h01}, '{2'b00, 2'b10, 2'b00, 2'b00, 2'b01});
        seq('{8'h11, 8'h11, 8'h11, 8'h01}, '{2'b00, 2'b00, 2'b00, 2'b00});
        seq('{8'h11, 8'h11, 8'h01}, '{2'b00, 2'b00, 2'b10});
        seq('{8'h01, 8'h01, 8'h01, 8'hff, 8'h01}, '{2'b00, 2'b00, 2'b00, 2'b00, 2'b10});
        cfg(8'h10, 8'h08, 8'h00, 8'h04);
        seq('{8'h11, 8'h01, 8'h01, 8'h11, 8'h01}, '{2'b00, 2'b10, 2'b00, 2'b00, 2'b10});
        odr_sel = 3'h3;
        cfg(8'h10, 8'h20, 8'h08, 8'h10);
        seq('{8'h11, 8'h01, 8'h01, 8'h11, 8'h01}, '{2'b00, 2'b10, 2'b00, 2'b00, 2'b01});
        odr_sel = 3'h7;
        cfg(8'h10, 8'h04, 8'h02, 8'h04);
        seq('{8'h11, 8'h11, 8'h01, 8'h11, 8'h01}, '{2'b00, 2'b00, 2'b00, 2'b00, 2'b10});
        odr_sel = 3'h5;
        cfg(8'h00, 8'h08, 8'h02, 8'h04);
        seq('{8'h11, 8'h01}, '{2'b00, 2'b00});
        cfg(8'h10, 8'h08, 8'h02, 8'h04);
        host.wr(8'h2d, 8'h00);
        seq('{8'h11, 8'h01}, '{2'b00, 2'b00});
        ce = 1'b0;
        host.wr(8'h2f, 8'h55);
        ce = 1'b1;
        host.rd(8'h2f, d);
        check("frozen write", d, 8'h10);
        $display("test taps done");
    endtask
    initial
    begin
        ce = 1'b1;
        int_sample_tick = 1'b0;
        outside_timebase_pin = 1'b0;
        sample_valid = 1'b0;
        tap_magnitude = 8'h00;
        motion_link_mode = 2'b00;
        odr_sel = 3'h5;
        nrst = 1'b0;
        repeat (2) @(posedge ref_clk);
        #1;
        nrst = 1'b1;
        t_reset;
        t_modes;
        t_tick;
        t_taps;
        host.wr(8'h2d, 8'h5e);
        nrst = 1'b0;
        @(posedge ref_clk);
        #1;
        nrst = 1'b1;
        t_reset;
        wrap_up;
    end
endmodule
bind power_tap_config power_tap_config_properties chk (.*);
`default_nettype wire
